/* File: hw/ecc_defs.svh */
`ifndef ECC_DEFS_SVH
`define ECC_DEFS_SVH

// Register byte offsets
`define ECC_OFS_WORD_N     8'h00
`define ECC_OFS_WORD_N1    8'h04
`define ECC_OFS_CTRL       8'h08
`define ECC_OFS_READ_M     8'h0C
`define ECC_OFS_READ_M1    8'h10
`define ECC_OFS_STATUS     8'h14

// Control word bit positions
`define ECC_B_SV1_SET      0
`define ECC_B_SV2_SET      1
`define ECC_B_CNT_SET      2
`define ECC_B_HEX          3
`define ECC_B_MODE_LO      4
`define ECC_B_READ         6
`define ECC_B_CNT_RST      7
`define ECC_B_COMPARE_OUTPUT_ONE_EN      8
`define ECC_B_COMPARE_OUTPUT_TWO_EN      9

// Bit of word n+1 holding the output condition (1: greater-or-equal)
`define ECC_B_COND         15

// Status word bit positions
`define ECC_B_ST_COMPARE_OUTPUT_ONE      8
`define ECC_B_ST_COMPARE_OUTPUT_TWO      9
`define ECC_B_ST_RANGE     12

// Reset values and limits
`define ECC_CTRL_RST       16'h0000
`define ECC_CNT_MAX        24'h7F_FFFF
`define ECC_CNT_MIN        24'h80_0000

`endif

/* File: hw/ecc_pkg.sv */
package ecc_pkg;

  typedef enum logic [1:0] {
    ECC_MODE_OFF,
    ECC_MODE_PULSE_DIR,
    ECC_MODE_QUAD_X1,
    ECC_MODE_QUAD_X4
  } ecc_mode_e;

  typedef struct packed {
    logic a_rise;
    logic a_fall;
    logic b_rise;
    logic b_fall;
  } ecc_edge_s;

  typedef struct packed {
    logic green;
    logic red;
  } ecc_led_s;

endpackage

/* File: hw/ecc_counter_top.sv */
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ecc_defs.svh"

module ecc_counter_top #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic             SYS_CLK_IN,
  input  wire logic             SYS_RST_IN,
  // APB slave
  input  wire logic             PSEL_IN,
  input  wire logic             PENABLE_IN,
  input  wire logic             PWRITE_IN,
  input  wire logic [7:0]       PADDR_IN,
  input  wire logic [31:0]      PWDATA_IN,
  output logic      [31:0]      PRDATA_OUT,
  output logic                  PREADY_OUT,
  output logic                  PSLVERR_OUT,
  // Encoder
  input  wire logic             PHASE_A_IN,
  input  wire logic             PHASE_B_IN,
  // Interface health
  input  wire logic             IF_ERR_IN,
  // Outputs
  output logic                  COMPARE_OUTPUT_ONE_OUT,
  output logic                  COMPARE_OUTPUT_TWO_OUT,
  output ecc_pkg::ecc_led_s     LINK_STATUS_INDICATOR_OUT
);

  function automatic logic [CNT_W-1:0] dec_val(input logic [31:0] w, input logic hex);
    logic [CNT_W-1:0] acc;
    acc = '0;
    if (hex) begin
      return w[CNT_W-1:0];
    end
    for (int i = 6; i >= 0; i--) begin
      acc = CNT_W'(acc * CNT_W'(10)) + CNT_W'(w[i*4 +: 4]);
    end
    return (w[30:28] != 3'h0) ? CNT_W'(-acc) : acc;
  endfunction

  function automatic logic [31:0] enc_val(input logic [CNT_W-1:0] c, input logic hex);
    logic [CNT_W-1:0] mag;
    logic [27:0]      bcd;
    mag = c[CNT_W-1] ? CNT_W'(-c) : c;
    bcd = '0;
    if (hex) begin
      return {8'h00, c};
    end
    for (int i = CNT_W - 1; i >= 0; i--) begin
      for (int d = 0; d < 7; d++) begin
        if (bcd[d*4 +: 4] >= 4'h5) begin
          bcd[d*4 +: 4] = bcd[d*4 +: 4] + 4'h3;
        end
      end
      bcd = {bcd[26:0], mag[i]};
    end
    return {(c[CNT_W-1] ? 4'hF : 4'h0), bcd};
  endfunction

  // APB decode
  wire        acc_phase = PSEL_IN & PENABLE_IN;
  wire        hit_n     = PADDR_IN == `ECC_OFS_WORD_N;
  wire        hit_n1    = PADDR_IN == `ECC_OFS_WORD_N1;
  wire        hit_ctrl  = PADDR_IN == `ECC_OFS_CTRL;
  wire        hit_m     = PADDR_IN == `ECC_OFS_READ_M;
  wire        hit_m1    = PADDR_IN == `ECC_OFS_READ_M1;
  wire        hit_st    = PADDR_IN == `ECC_OFS_STATUS;
  wire        known     = hit_n | hit_n1 | hit_ctrl | hit_m | hit_m1 | hit_st;
  wire        wr        = acc_phase & PWRITE_IN & known;
  wire        wr_ctrl   = wr & hit_ctrl;

  logic [15:0]      word_n_ff;
  logic [15:0]      word_n1_ff;
  logic [15:0]      ctrl_ff;
  logic [15:0]      read_m_ff;
  logic [15:0]      read_m1_ff;
  logic [31:0]      prdata_ff;
  logic             init_done_ff;
  ecc_pkg::ecc_led_s led_ff;
  logic [CNT_W-1:0] count_ff;
  logic             stop_ff;
  logic [1:0]       ph_s1_ff;
  logic [1:0]       ph_s2_ff;
  logic [1:0]       ph_d_ff;
  logic [CNT_W-1:0] sv_ff [2];
  logic [1:0]       cond_ff;
  logic [1:0]       out_ff;

  // Set/reset/read actions fire on a 0-to-1 write so a held bit acts once
  wire  [15:0] nxt_ctrl  = wr_ctrl ? PWDATA_IN[15:0] : ctrl_ff;
  wire  [15:0] ctrl_rise = wr_ctrl ? (PWDATA_IN[15:0] & ~ctrl_ff) : 16'h0000;
  wire         hex_sel   = nxt_ctrl[`ECC_B_HEX];
  wire  [31:0] host_word = {word_n1_ff, word_n_ff};
  wire  [CNT_W-1:0] host_val = dec_val(host_word, hex_sel);
  wire  [31:0] rd_word   = enc_val(count_ff, hex_sel);

  ecc_pkg::ecc_mode_e mode;
  ecc_pkg::ecc_mode_e nxt_mode;
  assign mode     = ecc_pkg::ecc_mode_e'(ctrl_ff[`ECC_B_MODE_LO +: 2]);
  assign nxt_mode = ecc_pkg::ecc_mode_e'(nxt_ctrl[`ECC_B_MODE_LO +: 2]);

  wire mode_chg = (nxt_mode != mode) && (mode != ecc_pkg::ECC_MODE_OFF);
  wire set_cnt  = ctrl_rise[`ECC_B_CNT_SET];
  wire rst_cnt  = ctrl_rise[`ECC_B_CNT_RST];
  wire host_act = mode_chg | set_cnt | rst_cnt;

  wire [31:0] status_word = {19'h0_0000, stop_ff, 2'b00, out_ff, 2'b00,
                             ctrl_ff[`ECC_B_MODE_LO +: 2], 4'h0};

  wire [31:0] rd_mux = hit_n    ? {16'h0000, word_n_ff}  :
                       hit_n1   ? {16'h0000, word_n1_ff} :
                       hit_ctrl ? {16'h0000, ctrl_ff}    :
                       hit_m    ? {16'h0000, read_m_ff}  :
                       hit_m1   ? {16'h0000, read_m1_ff} :
                       hit_st   ? status_word            : 32'h0000_0000;

  // Read data is latched in the setup phase, so zero wait states suffice
  assign PREADY_OUT  = 1'b1;
  assign PSLVERR_OUT = acc_phase & ~known;
  assign PRDATA_OUT  = prdata_ff;

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      word_n_ff    <= 16'h0000;
      word_n1_ff   <= 16'h0000;
      ctrl_ff      <= `ECC_CTRL_RST;
      read_m_ff    <= 16'h0000;
      read_m1_ff   <= 16'h0000;
      prdata_ff    <= 32'h0000_0000;
      init_done_ff <= 1'b0;
    end else begin
      if (wr & hit_n) begin
        word_n_ff <= PWDATA_IN[15:0];
      end
      if (wr & hit_n1) begin
        word_n1_ff <= PWDATA_IN[15:0];
      end
      ctrl_ff <= nxt_ctrl;
      if (ctrl_rise[`ECC_B_READ]) begin
        read_m_ff  <= rd_word[15:0];
        read_m1_ff <= rd_word[31:16];
      end
      if (PSEL_IN & ~PENABLE_IN) begin
        prdata_ff <= rd_mux;
      end
      if (acc_phase) begin
        init_done_ff <= 1'b1;
      end
    end
  end

  // Indicator: dark until the host first talks to the block
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      led_ff <= '0;
    end else begin
      led_ff.green <= init_done_ff & ~IF_ERR_IN;
      led_ff.red   <= init_done_ff & IF_ERR_IN;
    end
  end
  assign LINK_STATUS_INDICATOR_OUT = led_ff;

  // Two-stage sync, then a third stage for edge detection
  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      ph_s1_ff <= 2'b00;
      ph_s2_ff <= 2'b00;
      ph_d_ff  <= 2'b00;
    end else begin
      ph_s1_ff <= {PHASE_B_IN, PHASE_A_IN};
      ph_s2_ff <= ph_s1_ff;
      ph_d_ff  <= ph_s2_ff;
    end
  end

  wire a = ph_s2_ff[0];
  wire b = ph_s2_ff[1];
  ecc_pkg::ecc_edge_s edg;
  assign edg.a_rise = a & ~ph_d_ff[0];
  assign edg.a_fall = ~a & ph_d_ff[0];
  assign edg.b_rise = b & ~ph_d_ff[1];
  assign edg.b_fall = ~b & ph_d_ff[1];

  // Forward: A rises with B low; reverse: A falls with B low
  wire x4_up = (edg.a_rise & ~b) | (edg.a_fall & b) | (edg.b_rise & a) | (edg.b_fall & ~a);
  wire x4_dn = (edg.a_rise & b) | (edg.a_fall & ~b) | (edg.b_rise & ~a) | (edg.b_fall & a);

  logic step_up;
  logic step_dn;
  always_comb begin
    step_up = 1'b0;
    step_dn = 1'b0;
    unique case (mode)
      ecc_pkg::ECC_MODE_OFF: begin
        step_up = 1'b0;
      end
      ecc_pkg::ECC_MODE_PULSE_DIR: begin
        step_up = edg.a_rise & ~b;
        step_dn = edg.a_rise & b;
      end
      ecc_pkg::ECC_MODE_QUAD_X1: begin
        step_up = edg.a_rise & ~b;
        step_dn = edg.a_fall & ~b;
      end
      ecc_pkg::ECC_MODE_QUAD_X4: begin
        step_up = x4_up;
        step_dn = x4_dn;
      end
    endcase
  end

  logic [CNT_W-1:0] nxt_count;
  logic             nxt_stop;
  always_comb begin
    nxt_count = count_ff;
    nxt_stop  = stop_ff;
    if (mode_chg) begin
      nxt_count = '0;
    end else if (set_cnt) begin
      nxt_count = host_val;
      nxt_stop  = 1'b0;
    end else if (rst_cnt) begin
      nxt_count = '0;
      nxt_stop  = 1'b0;
    end else if (!stop_ff && step_up) begin
      if (count_ff == `ECC_CNT_MAX) begin
        nxt_stop = 1'b1;
      end else begin
        nxt_count = count_ff + CNT_W'(1);
      end
    end else if (!stop_ff && step_dn) begin
      if (count_ff == `ECC_CNT_MIN) begin
        nxt_stop = 1'b1;
      end else begin
        nxt_count = count_ff - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (SYS_RST_IN) begin
      count_ff <= '0;
      stop_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      stop_ff  <= nxt_stop;
    end
  end

  // Set values and comparison, one slice per output
  wire [1:0] out_en = {ctrl_ff[`ECC_B_COMPARE_OUTPUT_TWO_EN], ctrl_ff[`ECC_B_COMPARE_OUTPUT_ONE_EN]};
  wire [1:0] sv_set = {ctrl_rise[`ECC_B_SV2_SET], ctrl_rise[`ECC_B_SV1_SET]};
  for (genvar g = 0; g < 2; g++) begin : g_cmp
    wire signed [CNT_W-1:0] cnt_s = count_ff;
    wire signed [CNT_W-1:0] sv_s  = sv_ff[g];
    wire hit = cond_ff[g] ? (cnt_s >= sv_s) : (cnt_s <= sv_s);
    always_ff @(posedge SYS_CLK_IN) begin
      if (SYS_RST_IN) begin
        sv_ff[g]   <= '0;
        cond_ff[g] <= 1'b0;
        out_ff[g]  <= 1'b0;
      end else begin
        if (sv_set[g]) begin
          sv_ff[g]   <= host_val;
          cond_ff[g] <= word_n1_ff[`ECC_B_COND];
        end
        out_ff[g] <= out_en[g] & hit;
      end
    end
  end

  assign COMPARE_OUTPUT_ONE_OUT = out_ff[0];
  assign COMPARE_OUTPUT_TWO_OUT = out_ff[1];

  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);

  property p_mode_clear;
    mode_chg |=> count_ff == '0;
  endproperty
  a_mode_clear: assert property (p_mode_clear) else $error("count not cleared");

  property p_x1_up;
    (mode == ecc_pkg::ECC_MODE_QUAD_X1) && edg.a_rise && !b && !stop_ff && !host_act
      && count_ff != `ECC_CNT_MAX |=> count_ff == $past(count_ff) + CNT_W'(1);
  endproperty
  a_x1_up: assert property (p_x1_up) else $error("x1 forward miss");

  property p_x4_dn;
    (mode == ecc_pkg::ECC_MODE_QUAD_X4) && edg.b_fall && a && !stop_ff && !host_act
      && count_ff != `ECC_CNT_MIN |=> count_ff == $past(count_ff) - CNT_W'(1);
  endproperty
  a_x4_dn: assert property (p_x4_dn) else $error("x4 reverse miss");

  property p_pd_dn;
    (mode == ecc_pkg::ECC_MODE_PULSE_DIR) && edg.a_rise && b && !stop_ff && !host_act
      && count_ff != `ECC_CNT_MIN |=> count_ff == $past(count_ff) - CNT_W'(1);
  endproperty
  a_pd_dn: assert property (p_pd_dn) else $error("pulse/dir down miss");

  property p_off_hold;
    (mode == ecc_pkg::ECC_MODE_OFF) && !host_act |=> $stable(count_ff);
  endproperty
  a_off_hold: assert property (p_off_hold) else $error("counted with no mode");

  property p_ovf;
    count_ff == `ECC_CNT_MAX && step_up && !host_act
      |=> stop_ff && count_ff == `ECC_CNT_MAX && status_word[`ECC_B_ST_RANGE];
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not stopped");

  property p_stop_hold;
    stop_ff && !host_act |=> $stable(count_ff) ##1 1'b1;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("counted while stopped");

  property p_out_dis;
    !ctrl_ff[`ECC_B_COMPARE_OUTPUT_ONE_EN] |=> !COMPARE_OUTPUT_ONE_OUT;
  endproperty
  a_out_dis: assert property (p_out_dis) else $error("disabled output on");

  property p_cmp_ge;
    ctrl_ff[`ECC_B_COMPARE_OUTPUT_ONE_EN] && cond_ff[0] && ($signed(count_ff) >= $signed(sv_ff[0]))
      |=> COMPARE_OUTPUT_ONE_OUT;
  endproperty
  a_cmp_ge: assert property (p_cmp_ge) else $error("ge compare wrong");

  property p_led_red;
    init_done_ff && IF_ERR_IN |=> LINK_STATUS_INDICATOR_OUT.red && !LINK_STATUS_INDICATOR_OUT.green;
  endproperty
  a_led_red: assert property (p_led_red) else $error("indicator not red");

endmodule
`default_nettype wire

/* File: tb/ecc_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ecc_enc_model (
  // Clock
  input  wire logic clk_in,
  // Encoder phases
  output logic      phase_a_out,
  output logic      phase_b_out
);
  logic [1:0] quad_pos;

  initial begin
    quad_pos    = 2'h0;
    phase_a_out = 1'b0;
    phase_b_out = 1'b0;
  end

  // Each level held 4 cycles, longer than the 3-flop input chain
  task automatic quad(input logic fwd, input int quarters);
    for (int i = 0; i < quarters; i++) begin
      @(posedge clk_in);
      quad_pos = fwd ? quad_pos + 2'h1 : quad_pos - 2'h1;
      phase_a_out <= (quad_pos == 2'h1) || (quad_pos == 2'h2);
      phase_b_out <= quad_pos[1];
      repeat (3) @(posedge clk_in);
    end
  endtask

  task automatic pulse(input logic down, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_in);
      phase_b_out <= down;
      repeat (4) @(posedge clk_in);
      phase_a_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      phase_a_out <= 1'b0;
      repeat (3) @(posedge clk_in);
    end
  endtask
endmodule

`default_nettype wire

/* File: tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecc_defs.svh"

module tb;
  logic              clk, rst, psel, penable, pwrite, if_err;
  logic              pready, pslverr, compare_output_one, compare_output_two, ph_a, ph_b;
  logic [7:0]        paddr;
  logic [31:0]       pwdata, prdata, c;
  logic [15:0]       ctrl_v;
  ecc_pkg::ecc_led_s led;
  int                n_errors = 0;
  int                comparisons = 0;

  ecc_counter_top dut_u (
    .SYS_CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
    .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PHASE_A_IN(ph_a), .PHASE_B_IN(ph_b),
    .IF_ERR_IN(if_err), .COMPARE_OUTPUT_ONE_OUT(compare_output_one), .COMPARE_OUTPUT_TWO_OUT(compare_output_two),
    .LINK_STATUS_INDICATOR_OUT(led));
  ecc_enc_model enc_u (.clk_in(clk), .phase_a_out(ph_a), .phase_b_out(ph_b));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
  endtask

  // Mode 0 off, 1 pulse/dir, 2 quad x1, 3 quad x4
  task automatic ctl(input logic [1:0] m, input logic hex, input logic [1:0] en);
    ctrl_v = {6'h00, en, 2'h0, m, hex, 3'h0};
    wr(`ECC_OFS_CTRL, {16'h0000, ctrl_v});
  endtask

  // Action bits act on a rising write, so set then drop
  task automatic hit(input int b);
    wr(`ECC_OFS_CTRL, {16'h0000, ctrl_v | (16'h0001 << b)});
    wr(`ECC_OFS_CTRL, {16'h0000, ctrl_v});
  endtask

  task automatic load(input int b, input logic [31:0] v);
    wr(`ECC_OFS_WORD_N, {16'h0000, v[15:0]});
    wr(`ECC_OFS_WORD_N1, {16'h0000, v[31:16]});
    hit(b);
  endtask

  task automatic cnt(input string what, input logic [31:0] exp);
    logic [31:0] r0, r1;
    hit(`ECC_B_READ);
    rd(`ECC_OFS_READ_M, r0);
    rd(`ECC_OFS_READ_M1, r1);
    chk(what, exp, {r1[15:0], r0[15:0]});
  endtask

  task automatic stat(input logic exp);
    rd(`ECC_OFS_STATUS, c);
    chk("range flag", 32'(exp), 32'(c[`ECC_B_ST_RANGE]));
  endtask

  task automatic outs(input string what, input logic [1:0] exp);
    repeat (3) @(posedge clk);
    chk(what, 32'(exp), 32'({compare_output_two, compare_output_one}));
  endtask

  task automatic t_reset;
    chk("led at init", 32'h0000_0000, 32'(led));
    chk("outs at reset", 32'h0000_0000, 32'({compare_output_two, compare_output_one}));
    enc_u.quad(1'b1, 4);
    cnt("count mode off", 32'h0000_0000);
    repeat (2) @(posedge clk);
    chk("led normal", 32'h0000_0002, 32'(led));
    $display("t_reset done");
  endtask

  task automatic t_quad;
    ctl(2'h2, 1'b1, 2'h0);
    enc_u.quad(1'b1, 8);
    cnt("x1 forward", 32'h0000_0002);
    enc_u.quad(1'b0, 4);
    cnt("x1 reverse", 32'h0000_0001);
    ctl(2'h3, 1'b1, 2'h0);
    cnt("mode change clear", 32'h0000_0000);
    enc_u.quad(1'b1, 4);
    cnt("x4 forward", 32'h0000_0004);
    enc_u.quad(1'b0, 8);
    cnt("x4 reverse", 32'h00FF_FFFC);
    $display("t_quad done");
  endtask

  task automatic t_pdir;
    ctl(2'h1, 1'b1, 2'h0);
    enc_u.pulse(1'b0, 3);
    cnt("pulse up", 32'h0000_0003);
    enc_u.pulse(1'b1, 2);
    cnt("pulse down", 32'h0000_0001);
    $display("t_pdir done");
  endtask

  task automatic t_range;
    load(`ECC_B_CNT_SET, {8'h00, `ECC_CNT_MAX});
    enc_u.pulse(1'b0, 2);
    cnt("overflow hold", 32'h007F_FFFF);
    stat(1'b1);
    load(`ECC_B_CNT_SET, 32'h0000_0000);
    stat(1'b0);
    enc_u.pulse(1'b0, 1);
    cnt("count resumes", 32'h0000_0001);
    load(`ECC_B_CNT_SET, {8'h00, `ECC_CNT_MIN});
    enc_u.pulse(1'b1, 1);
    cnt("underflow hold", 32'h0080_0000);
    stat(1'b1);
    $display("t_range done");
  endtask

  task automatic t_cmp;
    load(`ECC_B_SV1_SET, 32'h8000_0005);
    load(`ECC_B_SV2_SET, 32'h0000_0005);
    load(`ECC_B_CNT_SET, 32'h0000_0003);
    outs("outs disabled", 2'h0);
    ctl(2'h1, 1'b1, 2'h3);
    outs("count 3", 2'h2);
    enc_u.pulse(1'b0, 2);
    outs("count 5", 2'h3);
    enc_u.pulse(1'b0, 2);
    outs("count 7", 2'h1);
    ctl(2'h1, 1'b1, 2'h2);
    outs("out one gated", 2'h0);
    ctl(2'h1, 1'b0, 2'h2);
    load(`ECC_B_CNT_SET, 32'h0000_0012);
    cnt("bcd read", 32'h0000_0012);
    load(`ECC_B_CNT_SET, 32'hF000_0003);
    cnt("bcd negative", 32'hF000_0003);
    ctl(2'h1, 1'b1, 2'h2);
    cnt("hex negative", 32'h00FF_FFFD);
    $display("t_cmp done");
  endtask

  task automatic t_apb;
    logic e;
    apb(1'b0, 8'h20, 32'h0000_0000, c, e);
    chk("unmapped data", 32'h0000_0000, c);
    chk("unmapped error", 32'h0000_0001, 32'(e));
    @(posedge clk) if_err <= 1'b1;
    repeat (3) @(posedge clk);
    chk("led error", 32'h0000_0001, 32'(led));
    @(posedge clk) if_err <= 1'b0;
    repeat (3) @(posedge clk);
    chk("led back", 32'h0000_0002, 32'(led));
    $display("t_apb done");
  endtask

  task automatic tally_and_finish;
    $display("Compares %0d, mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    n_errors++;
    tally_and_finish();
  end

  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    if_err = 1'b0;
    ctrl_v = 16'h0000;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_quad();
    t_pdir();
    t_range();
    t_cmp();
    t_apb();
    tally_and_finish();
  end
endmodule

`default_nettype wire
